// ### design/sbdlwb_pkg.sv
// Shared constants, commands, address-space codes and carriers for the bus-side block
package sbdlwb_pkg;

  // System address field positions
  localparam int ADDR_W = 34;
  localparam int QUAD_HI = 33;
  localparam int QUAD_LO = 32;
  localparam int SUB_HI = 31;
  localparam int SUB_LO = 29;
  localparam int LINE_LO = 5;
  localparam int LINE_W = ADDR_W - LINE_LO;
  localparam int LOCK_HI = 32;
  localparam int LOCK_W = LOCK_HI - LINE_LO + 1;
  localparam int INV_HI = 12;
  localparam int INV_W = INV_HI - LINE_LO + 1;
  localparam int OCTA_BIT = 4;

  // Address map codes
  localparam logic [1:0] QUAD_CACHEABLE = 2'h0;
  localparam logic [1:0] QUAD_LOW_IO = 2'h1;
  localparam logic [2:0] SUB_CSR = 3'h4;

  // Tag compare window: bit 17 (smallest cache) up to bit 31
  localparam int TAG_HI = 31;
  localparam int TAG_LO = 17;
  localparam int TAG_W = TAG_HI - TAG_LO + 1;
  localparam logic [TAG_W-1:0] TAG_EN_SMALLEST = 15'h7fff;
  localparam logic [TAG_W-1:0] TAG_EN_LARGEST = 15'h7f80;

  // Write buffer entry fields
  localparam int LW_MASK_W = 8;
  localparam int BANKSET_W = 3;
  localparam int BANK_W = 2;
  localparam int WB_DEPTH_DEF = 4;

  // Register port
  localparam int REG_ADDR_W = 8;
  localparam int REG_DATA_W = 32;
  localparam logic [REG_ADDR_W-1:0] REG_TAG_ENABLE = 8'h00;
  localparam logic [REG_ADDR_W-1:0] REG_CONTROL = 8'h04;
  localparam logic [REG_ADDR_W-1:0] REG_LOCK_ADDRESS = 8'h08;
  localparam logic [REG_ADDR_W-1:0] REG_STATUS = 8'h0c;
  localparam int CTRL_BCACHE_EN = 0;
  localparam logic CTRL_BCACHE_EN_RESET = 1'h1;
  localparam int ST_LOCK = 0;
  localparam int ST_FULL = 1;
  localparam int ST_STALL = 2;
  localparam int ST_FLUSH = 3;
  localparam int ST_RD_PEND = 4;
  localparam int ST_COUNT_LO = 8;

  typedef enum logic [3:0] {
    CMD_IDLE,
    CMD_CPU_READ,
    CMD_CPU_WRITE,
    CMD_LOAD_LOCKED,
    CMD_STORE_CONDITIONAL,
    CMD_DMA_READ,
    CMD_DMA_WRITE,
    CMD_DMA_MASKED_WRITE,
    CMD_DMA_FLUSH
  } sbdlwb_cmd_e;

  typedef enum logic [1:0] {
    SPACE_CACHEABLE,
    SPACE_NONCACHEABLE,
    SPACE_CSR,
    SPACE_PCI
  } sbdlwb_space_e;

  typedef struct packed {
    sbdlwb_cmd_e cmd;
    logic [ADDR_W-1:0] addr;
    logic istream;
  } sbdlwb_req_s;

  typedef struct packed {
    logic [LINE_W-1:0] line_addr;
    logic [LW_MASK_W-1:0] lw_mask;
    logic [BANKSET_W-1:0] bankset;
    logic [BANK_W-1:0] bank;
  } sbdlwb_wbent_s;

  typedef struct packed {
    logic valid;
    logic istream;
    logic write_alloc;
    logic victim_valid;
    logic [LINE_W-1:0] line_addr;
  } sbdlwb_fill_s;

endpackage

// ### design/sbdlwb_tagcmp.sv
// Masked backup-cache tag comparator with parity over the enabled bits
module sbdlwb_tagcmp (
  input wire logic [sbdlwb_pkg::TAG_W-1:0] addr_bits,
  input wire logic [sbdlwb_pkg::TAG_W-1:0] stored_tag_bits,
  input wire logic stored_parity,
  input wire logic [sbdlwb_pkg::TAG_W-1:0] tag_enable,
  output logic match,
  output logic parity_error
);

  // Bits above the cache index take part only where enabled
  always_comb begin
    match = ((addr_bits ^ stored_tag_bits) & tag_enable) == '0;
    parity_error = (^(stored_tag_bits & tag_enable)) ^ stored_parity;
  end

endmodule

// ### design/sbdlwb_top.sv
// Bus-side decode, tag compare, invalidate, lock and memory write buffer
//
// Contract
// - Compare tags on load-locked, store-conditional and DMA to cacheable memory.
// - Tag enable setting picks bits used for tag compare and parity check.
// - Smallest cache compares bits 31:17; largest only 31:24.
// - Request data-cache invalidate when valid block replaced by Istream or allocate fill.
// - Invalidate on DMA write hit, and every DMA write with cache off.
// - Reads return the requested octaword first, wrapped order.
// - Quadrant 00 is cacheable memory; answer every access there.
// - Quadrant 01, sub 0XX is noncacheable memory, bypassing the cache.
// - Quadrant 01, sub 100 is own CSR space, data-stream only.
// - Quadrant 01 sub 101/11X and quadrants 10/11 belong to PCI chip.
// - Load-locked captures address bits 32:5 and sets lock bit.
// - Lock clears on reset, matching DMA write, store-conditional, I/O write, clear command.
// - Write buffer holds four writes: DMA, victims, CPU noncacheable writes.
// - Entry keeps line address, longword masks, bankset, bank, valid bit.
// - Reads compare against valid entries; without match read goes first.
// - On match, drain one line per step until no match, then read.
// - Comparison covers CPU/DMA reads, DMA masked writes, partial CPU writes.
// - Flush command empties the write buffer to memory.
// - When full, latch first data and stall the rest until a retire.
module sbdlwb_top #(
  parameter int WB_DEPTH = sbdlwb_pkg::WB_DEPTH_DEF
) (
  input wire logic CLK,
  input wire logic RSTN,
  input wire logic [sbdlwb_pkg::REG_ADDR_W-1:0] REG_ADDR,
  input wire logic [sbdlwb_pkg::REG_DATA_W-1:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [sbdlwb_pkg::REG_DATA_W-1:0] REG_RDATA,
  input wire sbdlwb_pkg::sbdlwb_req_s REQ,
  input wire logic [sbdlwb_pkg::TAG_W-1:0] STORED_TAG_BITS,
  input wire logic STORED_TAG_PARITY,
  input wire logic STORED_TAG_VALID,
  input wire logic PCI_SIDE_CLEAR_LOCK_CMD,
  input wire sbdlwb_pkg::sbdlwb_fill_s FILL,
  input wire logic WB_IN_VALID,
  input wire sbdlwb_pkg::sbdlwb_wbent_s WB_IN_ENTRY,
  input wire logic RD_REQ_VALID,
  input wire logic [sbdlwb_pkg::LINE_W-1:0] RD_REQ_LINE,
  input wire logic MEM_WR_DONE,
  output sbdlwb_pkg::sbdlwb_space_e SPACE,
  output logic OWN_RESPOND,
  output logic TAG_CHECKED,
  output logic TAG_HIT,
  output logic TAG_PARITY_ERROR,
  output logic RD_FIRST_OCTA,
  output logic SC_SUCCESS,
  output logic LOCK_FLAG,
  output logic DCACHE_INVALIDATE_REQUEST,
  output logic [sbdlwb_pkg::INV_W-1:0] CPU_INVALIDATE_INDEX,
  output logic WB_FULL,
  output logic WB_STALL,
  output logic FLUSH_BUSY,
  output logic RD_PENDING,
  output logic MEM_RD_START,
  output logic [sbdlwb_pkg::LINE_W-1:0] MEM_RD_LINE,
  output logic MEM_WR_VALID,
  output sbdlwb_pkg::sbdlwb_wbent_s MEM_WR_ENTRY
);

  localparam int PTR_W = (WB_DEPTH > 1) ? $clog2(WB_DEPTH) : 1;
  localparam int CNT_W = $clog2(WB_DEPTH + 1);
  localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(WB_DEPTH);
  localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);
  localparam logic [PTR_W-1:0] PTR_ONE = PTR_W'(1);
  localparam logic [PTR_W-1:0] PTR_LAST = PTR_W'(WB_DEPTH - 1);

  typedef struct packed {
    logic [sbdlwb_pkg::TAG_W-1:0] tag_enable;
    logic bcache_en;
    logic [sbdlwb_pkg::REG_DATA_W-1:0] rdata;
    sbdlwb_pkg::sbdlwb_space_e space;
    logic own_respond;
    logic tag_checked;
    logic tag_hit;
    logic tag_perr;
    logic rd_first_octa;
    logic sc_success;
    logic lock_flag;
    logic [sbdlwb_pkg::LOCK_W-1:0] lock_addr;
    logic inv_req;
    logic [sbdlwb_pkg::INV_W-1:0] inv_index;
    sbdlwb_pkg::sbdlwb_wbent_s [WB_DEPTH-1:0] ent;
    logic [WB_DEPTH-1:0] vld;
    logic [PTR_W-1:0] wr_ptr;
    logic [PTR_W-1:0] rd_ptr;
    logic [CNT_W-1:0] count;
    logic full;
    logic hold_valid;
    sbdlwb_pkg::sbdlwb_wbent_s hold_ent;
    logic flush_busy;
    logic rd_pending;
    logic [sbdlwb_pkg::LINE_W-1:0] rd_line;
    logic mem_rd_start;
    logic [sbdlwb_pkg::LINE_W-1:0] mem_rd_line;
    logic mem_wr_valid;
    sbdlwb_pkg::sbdlwb_wbent_s mem_wr_entry;
  } sbdlwb_state_s;

  sbdlwb_state_s st_reg;
  sbdlwb_state_s st_next;
  logic tag_match;
  logic tag_perr;
  logic [WB_DEPTH-1:0] rd_match;

  sbdlwb_tagcmp u_tagcmp (
    .addr_bits(REQ.addr[sbdlwb_pkg::TAG_HI:sbdlwb_pkg::TAG_LO]),
    .stored_tag_bits(STORED_TAG_BITS),
    .stored_parity(STORED_TAG_PARITY),
    .tag_enable(st_reg.tag_enable),
    .match(tag_match),
    .parity_error(tag_perr)
  );

  // Pending read line against every valid buffered line
  for (genvar i = 0; i < WB_DEPTH; i++) begin : g_match
    assign rd_match[i] = st_reg.vld[i] && (st_reg.ent[i].line_addr == st_reg.rd_line);
  end

  function automatic logic [PTR_W-1:0] ptr_inc(input logic [PTR_W-1:0] p);
    ptr_inc = (p == PTR_LAST) ? '0 : p + PTR_ONE;
  endfunction

  always_comb begin
    logic [1:0] quad;
    logic [2:0] sub;
    logic is_read;
    logic is_dma_wr;
    logic is_cpu_io_wr;
    logic probe;
    logic retire;
    logic push;
    logic any_match;
    sbdlwb_pkg::sbdlwb_wbent_s push_ent;
    quad = REQ.addr[sbdlwb_pkg::QUAD_HI:sbdlwb_pkg::QUAD_LO];
    sub = REQ.addr[sbdlwb_pkg::SUB_HI:sbdlwb_pkg::SUB_LO];
    is_read = 1'b0;
    is_dma_wr = 1'b0;
    is_cpu_io_wr = 1'b0;
    probe = 1'b0;
    retire = 1'b0;
    push = 1'b0;
    any_match = |rd_match;
    push_ent = WB_IN_ENTRY;
    st_next = st_reg;
    st_next.tag_checked = 1'b0;
    st_next.sc_success = 1'b0;
    st_next.inv_req = 1'b0;
    st_next.mem_rd_start = 1'b0;
    st_next.rdata = '0;

    // Register port
    if (REG_WR) begin
      case (REG_ADDR)
        sbdlwb_pkg::REG_TAG_ENABLE: begin
          st_next.tag_enable = REG_WDATA[sbdlwb_pkg::TAG_W-1:0];
        end
        sbdlwb_pkg::REG_CONTROL: begin
          st_next.bcache_en = REG_WDATA[sbdlwb_pkg::CTRL_BCACHE_EN];
        end
        default: begin
        end
      endcase
    end
    if (REG_RD) begin
      case (REG_ADDR)
        sbdlwb_pkg::REG_TAG_ENABLE: begin
          st_next.rdata[sbdlwb_pkg::TAG_W-1:0] = st_reg.tag_enable;
        end
        sbdlwb_pkg::REG_CONTROL: begin
          st_next.rdata[sbdlwb_pkg::CTRL_BCACHE_EN] = st_reg.bcache_en;
        end
        sbdlwb_pkg::REG_LOCK_ADDRESS: begin
          st_next.rdata[sbdlwb_pkg::LOCK_W-1:0] = st_reg.lock_addr;
        end
        sbdlwb_pkg::REG_STATUS: begin
          st_next.rdata[sbdlwb_pkg::ST_LOCK] = st_reg.lock_flag;
          st_next.rdata[sbdlwb_pkg::ST_FULL] = (st_reg.count == CNT_FULL);
          st_next.rdata[sbdlwb_pkg::ST_STALL] = st_reg.hold_valid;
          st_next.rdata[sbdlwb_pkg::ST_FLUSH] = st_reg.flush_busy;
          st_next.rdata[sbdlwb_pkg::ST_RD_PEND] = st_reg.rd_pending;
          st_next.rdata[sbdlwb_pkg::ST_COUNT_LO +: CNT_W] = st_reg.count;
        end
        default: begin
        end
      endcase
    end

    // Address map; the PCI chip answers the reserved ranges itself
    if (quad == sbdlwb_pkg::QUAD_CACHEABLE) begin
      st_next.space = sbdlwb_pkg::SPACE_CACHEABLE;
    end else if (quad == sbdlwb_pkg::QUAD_LOW_IO && !sub[2]) begin
      st_next.space = sbdlwb_pkg::SPACE_NONCACHEABLE;
    end else if (quad == sbdlwb_pkg::QUAD_LOW_IO && sub == sbdlwb_pkg::SUB_CSR) begin
      st_next.space = sbdlwb_pkg::SPACE_CSR;
    end else begin
      st_next.space = sbdlwb_pkg::SPACE_PCI;
    end
    // CSR space takes data-stream accesses only
    st_next.own_respond = (REQ.cmd != sbdlwb_pkg::CMD_IDLE) &&
                          (st_next.space != sbdlwb_pkg::SPACE_PCI) &&
                          !(st_next.space == sbdlwb_pkg::SPACE_CSR && REQ.istream);

    // Command classes; only a CPU write to CSR or PCI space counts as an I/O write
    case (REQ.cmd)
      sbdlwb_pkg::CMD_CPU_READ,
      sbdlwb_pkg::CMD_LOAD_LOCKED,
      sbdlwb_pkg::CMD_DMA_READ: begin
        is_read = 1'b1;
      end
      sbdlwb_pkg::CMD_DMA_WRITE,
      sbdlwb_pkg::CMD_DMA_MASKED_WRITE: begin
        is_dma_wr = 1'b1;
      end
      sbdlwb_pkg::CMD_CPU_WRITE: begin
        is_cpu_io_wr = (st_next.space == sbdlwb_pkg::SPACE_CSR) ||
                       (st_next.space == sbdlwb_pkg::SPACE_PCI);
      end
      default: begin
      end
    endcase

    // Wrapped order: the addressed octaword goes out first
    if (is_read) begin
      st_next.rd_first_octa = REQ.addr[sbdlwb_pkg::OCTA_BIT];
    end

    // Tag probe
    probe = (REQ.cmd == sbdlwb_pkg::CMD_LOAD_LOCKED) ||
            (REQ.cmd == sbdlwb_pkg::CMD_STORE_CONDITIONAL) ||
            ((REQ.cmd == sbdlwb_pkg::CMD_DMA_READ || is_dma_wr) &&
             st_next.space == sbdlwb_pkg::SPACE_CACHEABLE);
    if (probe) begin
      st_next.tag_checked = 1'b1;
      st_next.tag_hit = tag_match && STORED_TAG_VALID && st_reg.bcache_en;
      st_next.tag_perr = tag_perr && STORED_TAG_VALID;
    end

    // Data-cache invalidate; a DMA write outranks a fill in the same cycle
    if (FILL.valid && FILL.victim_valid && (FILL.istream || FILL.write_alloc)) begin
      st_next.inv_req = 1'b1;
      st_next.inv_index = FILL.line_addr[sbdlwb_pkg::INV_W-1:0];
    end
    if (is_dma_wr && (!st_reg.bcache_en || (probe && st_next.tag_hit))) begin
      st_next.inv_req = 1'b1;
      st_next.inv_index = REQ.addr[sbdlwb_pkg::INV_HI:sbdlwb_pkg::LINE_LO];
    end

    // Lock bit: clears first so that a load-locked in the same cycle wins
    if (REQ.cmd == sbdlwb_pkg::CMD_STORE_CONDITIONAL) begin
      st_next.sc_success = st_reg.lock_flag;
      st_next.lock_flag = 1'b0;
    end
    if ((is_dma_wr && REQ.addr[sbdlwb_pkg::LOCK_HI:sbdlwb_pkg::LINE_LO] == st_reg.lock_addr) ||
        is_cpu_io_wr || PCI_SIDE_CLEAR_LOCK_CMD) begin
      st_next.lock_flag = 1'b0;
    end
    if (REQ.cmd == sbdlwb_pkg::CMD_LOAD_LOCKED) begin
      st_next.lock_addr = REQ.addr[sbdlwb_pkg::LOCK_HI:sbdlwb_pkg::LINE_LO];
      st_next.lock_flag = 1'b1;
    end

    // Retire the head entry, oldest first
    retire = st_reg.mem_wr_valid && MEM_WR_DONE;
    if (retire) begin
      st_next.vld[st_reg.rd_ptr] = 1'b0;
      st_next.rd_ptr = ptr_inc(st_reg.rd_ptr);
    end

    // Accept a write; when full the first data waits in the latch
    if (st_reg.hold_valid) begin
      push = (st_reg.count != CNT_FULL) || retire;
      push_ent = st_reg.hold_ent;
      st_next.hold_valid = !push;
    end else if (WB_IN_VALID) begin
      if ((st_reg.count != CNT_FULL) || retire) begin
        push = 1'b1;
      end else begin
        st_next.hold_valid = 1'b1;
        st_next.hold_ent = WB_IN_ENTRY;
      end
    end
    if (push) begin
      st_next.ent[st_reg.wr_ptr] = push_ent;
      st_next.vld[st_reg.wr_ptr] = 1'b1;
      st_next.wr_ptr = ptr_inc(st_reg.wr_ptr);
    end
    st_next.count = st_reg.count + (push ? CNT_ONE : '0) - (retire ? CNT_ONE : '0);
    st_next.full = (st_next.count == CNT_FULL);

    // Flush runs until buffer and latch are both empty
    if (REQ.cmd == sbdlwb_pkg::CMD_DMA_FLUSH) begin
      st_next.flush_busy = 1'b1;
    end else if (st_reg.flush_busy && st_next.count == '0 && !st_next.hold_valid) begin
      st_next.flush_busy = 1'b0;
    end

    // Read bypass: a matching read waits while lines drain one by one
    if (st_reg.rd_pending && !any_match) begin
      st_next.rd_pending = 1'b0;
      st_next.mem_rd_start = 1'b1;
      st_next.mem_rd_line = st_reg.rd_line;
    end
    if (!st_reg.rd_pending && RD_REQ_VALID) begin
      st_next.rd_pending = 1'b1;
      st_next.rd_line = RD_REQ_LINE;
    end

    // Writes go out unless an unmatched read is about to overtake them
    st_next.mem_wr_valid = (st_next.count != '0) &&
                           !(st_reg.rd_pending && !any_match);
    st_next.mem_wr_entry = st_next.ent[st_next.rd_ptr];
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      st_reg <= '0;
      st_reg.tag_enable <= sbdlwb_pkg::TAG_EN_SMALLEST;
      st_reg.bcache_en <= sbdlwb_pkg::CTRL_BCACHE_EN_RESET;
      st_reg.space <= sbdlwb_pkg::SPACE_CACHEABLE;
      st_reg.lock_flag <= 1'b0;
    end else begin
      st_reg <= st_next;
    end
  end

  always_comb begin
    REG_RDATA = st_reg.rdata;
    SPACE = st_reg.space;
    OWN_RESPOND = st_reg.own_respond;
    TAG_CHECKED = st_reg.tag_checked;
    TAG_HIT = st_reg.tag_hit;
    TAG_PARITY_ERROR = st_reg.tag_perr;
    RD_FIRST_OCTA = st_reg.rd_first_octa;
    SC_SUCCESS = st_reg.sc_success;
    LOCK_FLAG = st_reg.lock_flag;
    DCACHE_INVALIDATE_REQUEST = st_reg.inv_req;
    CPU_INVALIDATE_INDEX = st_reg.inv_index;
    WB_FULL = st_reg.full;
    WB_STALL = st_reg.hold_valid;
    FLUSH_BUSY = st_reg.flush_busy;
    RD_PENDING = st_reg.rd_pending;
    MEM_RD_START = st_reg.mem_rd_start;
    MEM_RD_LINE = st_reg.mem_rd_line;
    MEM_WR_VALID = st_reg.mem_wr_valid;
    MEM_WR_ENTRY = st_reg.mem_wr_entry;
  end

endmodule

// ### testbench/sbdlwb_top_assertions.sv
// Port-level checks on the bus-side decode, lock and write buffer block
module sbdlwb_chk (
  input wire logic CLK,
  input wire logic RSTN,
  input wire sbdlwb_pkg::sbdlwb_req_s REQ,
  input wire logic PCI_SIDE_CLEAR_LOCK_CMD,
  input wire logic RD_REQ_VALID,
  input wire logic MEM_WR_DONE,
  input wire sbdlwb_pkg::sbdlwb_space_e SPACE,
  input wire logic OWN_RESPOND,
  input wire logic TAG_CHECKED,
  input wire logic RD_FIRST_OCTA,
  input wire logic LOCK_FLAG,
  input wire logic WB_FULL,
  input wire logic WB_STALL,
  input wire logic FLUSH_BUSY,
  input wire logic RD_PENDING,
  input wire logic MEM_RD_START,
  input wire logic MEM_WR_VALID,
  input wire sbdlwb_pkg::sbdlwb_wbent_s MEM_WR_ENTRY
);
  default clocking dc @(posedge CLK); endclocking
  default disable iff (!RSTN);
  logic live, io, csr, pci, rdc;
  // Flush carries no address of interest, so it is kept out of the decode checks
  assign live = REQ.cmd != sbdlwb_pkg::CMD_IDLE && REQ.cmd != sbdlwb_pkg::CMD_DMA_FLUSH;
  assign io = REQ.addr[33:32] == sbdlwb_pkg::QUAD_LOW_IO;
  assign csr = io && REQ.addr[31:29] == sbdlwb_pkg::SUB_CSR;
  assign pci = REQ.addr[33] || (io && REQ.addr[31] && !csr);
  assign rdc = REQ.cmd inside {sbdlwb_pkg::CMD_CPU_READ, sbdlwb_pkg::CMD_DMA_READ};
  a_space_mem: assert property (live && REQ.addr[33:32] == 2'h0 |=>
    SPACE == sbdlwb_pkg::SPACE_CACHEABLE && OWN_RESPOND) else $error("cacheable decode");
  a_space_nc: assert property (live && io && !REQ.addr[31] |=>
    SPACE == sbdlwb_pkg::SPACE_NONCACHEABLE && OWN_RESPOND) else $error("noncache decode");
  a_space_csr: assert property (live && csr |=> SPACE == sbdlwb_pkg::SPACE_CSR
    && OWN_RESPOND == !$past(REQ.istream)) else $error("csr decode");
  a_space_pci: assert property (live && pci |=>
    SPACE == sbdlwb_pkg::SPACE_PCI && !OWN_RESPOND) else $error("pci decode");
  a_lock_probe: assert property (REQ.cmd == sbdlwb_pkg::CMD_LOAD_LOCKED |=>
    LOCK_FLAG && TAG_CHECKED) else $error("load locked");
  a_sc_clear: assert property (REQ.cmd == sbdlwb_pkg::CMD_STORE_CONDITIONAL |=>
    !LOCK_FLAG && TAG_CHECKED) else $error("store conditional");
  a_pci_clear: assert property (PCI_SIDE_CLEAR_LOCK_CMD &&
    REQ.cmd != sbdlwb_pkg::CMD_LOAD_LOCKED |=> !LOCK_FLAG) else $error("clear lock");
  a_octa_first: assert property (rdc |=> RD_FIRST_OCTA == $past(REQ.addr[4]))
    else $error("first octaword");
  a_rd_taken: assert property (RD_REQ_VALID && !RD_PENDING |=> RD_PENDING)
    else $error("read not taken");
  a_rd_bound: assert property ($rose(RD_PENDING) |-> ##[1:600] MEM_RD_START)
    else $error("read never started");
  a_stall_full: assert property (WB_STALL |-> WB_FULL) else $error("stall not full");
  a_stall_hold: assert property (WB_STALL && !(MEM_WR_VALID && MEM_WR_DONE) |=>
    WB_STALL) else $error("stall dropped early");
  a_head_hold: assert property (MEM_WR_VALID && !MEM_WR_DONE |=> MEM_RD_START ||
    (MEM_WR_VALID && $stable(MEM_WR_ENTRY))) else $error("head entry moved");
  a_flush_busy: assert property (REQ.cmd == sbdlwb_pkg::CMD_DMA_FLUSH |=> FLUSH_BUSY)
    else $error("flush not busy");
  a_flush_empty: assert property ($fell(FLUSH_BUSY) |-> !MEM_WR_VALID && !WB_STALL)
    else $error("flush ended early");
endmodule

bind sbdlwb_top sbdlwb_chk chk_u (.*);

// ### testbench/sbdlwb_mem_model.sv
// Memory side that retires write buffer lines after a delay, or holds them off
module sbdlwb_mem_model #(
  parameter int LAT = 2
) (
  input wire logic CLK,
  input wire logic RSTN,
  input wire logic MEM_WR_VALID,
  input wire logic GO,
  output logic MEM_WR_DONE
);
  int cnt_reg;
  // A few cycles per line, so no second retire slips in before a read starts
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      cnt_reg <= 0;
      MEM_WR_DONE <= 1'b0;
    end else begin
      MEM_WR_DONE <= MEM_WR_VALID && !MEM_WR_DONE && GO && cnt_reg >= LAT;
      cnt_reg <= (MEM_WR_VALID && !MEM_WR_DONE) ? cnt_reg + 1 : 0;
    end
  end
endmodule

// ### testbench/sbdlwb_top_test.sv
// Self-checking bench for the bus-side decode, lock and write buffer block
module sbdlwb_top_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic CLK = 1'b0, RSTN = 1'b0, REG_WR = 1'b0, REG_RD = 1'b0, go = 1'b0;
  logic STORED_TAG_PARITY = 1'b0, STORED_TAG_VALID = 1'b0, PCI_SIDE_CLEAR_LOCK_CMD = 1'b0;
  logic WB_IN_VALID = 1'b0, RD_REQ_VALID = 1'b0;
  logic [7:0] REG_ADDR = 8'h0;
  logic [31:0] REG_WDATA = 32'h0;
  logic [14:0] STORED_TAG_BITS = 15'h0;
  logic [28:0] RD_REQ_LINE = 29'h0;
  sbdlwb_pkg::sbdlwb_req_s REQ = '0;
  sbdlwb_pkg::sbdlwb_fill_s FILL = '0;
  sbdlwb_pkg::sbdlwb_wbent_s WB_IN_ENTRY = '0;
  sbdlwb_pkg::sbdlwb_space_e SPACE;
  logic OWN_RESPOND, TAG_CHECKED, TAG_HIT, TAG_PARITY_ERROR, RD_FIRST_OCTA, SC_SUCCESS;
  logic LOCK_FLAG, DCACHE_INVALIDATE_REQUEST, WB_FULL, WB_STALL, FLUSH_BUSY, RD_PENDING;
  logic MEM_RD_START, MEM_WR_VALID, MEM_WR_DONE;
  logic [7:0] CPU_INVALIDATE_INDEX;
  logic [28:0] MEM_RD_LINE;
  logic [31:0] REG_RDATA;
  sbdlwb_pkg::sbdlwb_wbent_s MEM_WR_ENTRY;
  sbdlwb_pkg::sbdlwb_wbent_s exp_q[$];
  int num_errors = 0, cmp_count = 0, ret_cnt = 0;
  localparam logic [33:0] A = 34'h0_1234_5660;

  sbdlwb_top #(.WB_DEPTH(4)) dut_u (.*);
  sbdlwb_mem_model mem_u (.CLK, .RSTN, .MEM_WR_VALID, .GO(go), .MEM_WR_DONE);

  always #5 CLK = ~CLK;

  task automatic end_sim();
    $display("Comparisons %0d, mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk(string n, logic [63:0] e, logic [63:0] g);
    cmp_count++;
    if (g !== e) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic wr(logic [7:0] a, logic [31:0] d);
    @(posedge CLK);
    REG_WR <= 1'b1;
    REG_ADDR <= a;
    REG_WDATA <= d;
    @(posedge CLK);
    REG_WR <= 1'b0;
  endtask

  task automatic rd(logic [7:0] a, logic [31:0] e);
    @(posedge CLK);
    REG_RD <= 1'b1;
    REG_ADDR <= a;
    @(posedge CLK);
    REG_RD <= 1'b0;
    #1 chk("REG_RDATA", e, REG_RDATA);
  endtask

  task automatic cmd(sbdlwb_pkg::sbdlwb_cmd_e c, logic [33:0] a, logic s);
    @(posedge CLK);
    REQ <= '{c, a, s};
    @(posedge CLK);
    REQ <= '0;
    #1;
  endtask

  task automatic fill(logic [3:0] k, logic [28:0] l);
    @(posedge CLK);
    FILL <= {k, l};
    @(posedge CLK);
    FILL <= '0;
    #1;
  endtask

  function automatic sbdlwb_pkg::sbdlwb_wbent_s ent(int i);
    return '{29'h100 + 29'(i), 8'h81 ^ 8'(i), 3'(i), 2'(i)};
  endfunction

  task automatic push(int i);
    @(posedge CLK);
    WB_IN_VALID <= 1'b1;
    WB_IN_ENTRY <= ent(i);
    @(posedge CLK);
    WB_IN_VALID <= 1'b0;
    #1;
  endtask

  task automatic rdreq(logic [28:0] l);
    @(posedge CLK);
    RD_REQ_VALID <= 1'b1;
    RD_REQ_LINE <= l;
    @(posedge CLK);
    RD_REQ_VALID <= 1'b0;
    #1 chk("RD_PENDING", 1, RD_PENDING);
  endtask

  // Bounded wait on a design output; running out counts as a mismatch
  task automatic wait_for(ref logic s, input logic v, input int lim, output int n);
    for (n = 0; s !== v; n++) begin
      if (n > lim) begin
        num_errors++;
        end_sim();
      end
      @(posedge CLK);
      #1;
    end
  endtask

  always @(posedge CLK) begin
    if (MEM_WR_VALID === 1'b1 && MEM_WR_DONE === 1'b1) begin
      chk("MEM_WR_ENTRY", exp_q.pop_front(), MEM_WR_ENTRY);
      ret_cnt++;
    end
  end

  initial begin
    #200us;
    num_errors++;
    end_sim();
  end

  initial begin
    int n;
    logic [33:0] da [7];
    logic [1:0] ds [7];
    logic [3:0] fk [4];
    da = '{34'h0_f000_0000, 34'h1_7fff_ffe0, 34'h1_8000_0000, 34'h1_a000_0000,
      34'h1_c000_0000, 34'h2_0000_0000, 34'h3_ffff_ffe0};
    ds = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h3, 2'h3, 2'h3};
    fk = '{4'hd, 4'hb, 4'hc, 4'h9};
    repeat (4) @(posedge CLK);
    RSTN <= 1'b1;
    rd(sbdlwb_pkg::REG_TAG_ENABLE, 32'h7fff);
    rd(sbdlwb_pkg::REG_CONTROL, 32'h1);
    rd(sbdlwb_pkg::REG_STATUS, 32'h0);
    rd(8'h40, 32'h0);
    for (int i = 0; i < 7; i++) begin
      cmd(sbdlwb_pkg::CMD_CPU_READ, da[i], 1'b0);
      chk("SPACE", ds[i], SPACE);
      chk("OWN_RESPOND", i < 3, OWN_RESPOND);
      chk("TAG_CHECKED", 0, TAG_CHECKED);
    end
    cmd(sbdlwb_pkg::CMD_CPU_READ, 34'h1_8000_0000, 1'b1);
    chk("OWN_RESPOND", 0, OWN_RESPOND);
    cmd(sbdlwb_pkg::CMD_CPU_READ, 34'h10, 1'b0);
    chk("RD_FIRST_OCTA", 1, RD_FIRST_OCTA);
    cmd(sbdlwb_pkg::CMD_DMA_READ, 34'h1_0000_0020, 1'b0);
    chk("RD_FIRST_OCTA", 0, RD_FIRST_OCTA);
    chk("TAG_CHECKED", 0, TAG_CHECKED);
    STORED_TAG_VALID <= 1'b1;
    STORED_TAG_BITS <= A[31:17];
    STORED_TAG_PARITY <= ^A[31:17];
    cmd(sbdlwb_pkg::CMD_DMA_READ, A, 1'b0);
    chk("TAG_CHECKED", 1, TAG_CHECKED);
    chk("TAG_HIT", 1, TAG_HIT);
    cmd(sbdlwb_pkg::CMD_LOAD_LOCKED, A, 1'b0);
    chk("LOCK_FLAG", 1, LOCK_FLAG);
    chk("TAG_PARITY_ERROR", 0, TAG_PARITY_ERROR);
    rd(sbdlwb_pkg::REG_LOCK_ADDRESS, 32'(A[32:5]));
    cmd(sbdlwb_pkg::CMD_STORE_CONDITIONAL, A, 1'b0);
    chk("SC_SUCCESS", 1, SC_SUCCESS);
    chk("LOCK_FLAG", 0, LOCK_FLAG);
    STORED_TAG_PARITY <= ~^A[31:17];
    cmd(sbdlwb_pkg::CMD_STORE_CONDITIONAL, A, 1'b0);
    chk("SC_SUCCESS", 0, SC_SUCCESS);
    chk("TAG_PARITY_ERROR", 1, TAG_PARITY_ERROR);
    STORED_TAG_PARITY <= ^A[31:17];
    for (int k = 0; k < 4; k++) begin
      cmd(sbdlwb_pkg::CMD_LOAD_LOCKED, A, 1'b0);
      case (k)
        0: cmd(sbdlwb_pkg::CMD_DMA_WRITE, A + 34'h20, 1'b0);
        1: cmd(sbdlwb_pkg::CMD_DMA_WRITE, A + 34'h8, 1'b0);
        2: cmd(sbdlwb_pkg::CMD_CPU_WRITE, 34'h1_8000_0000, 1'b0);
        default: begin
          @(posedge CLK);
          PCI_SIDE_CLEAR_LOCK_CMD <= 1'b1;
          @(posedge CLK);
          PCI_SIDE_CLEAR_LOCK_CMD <= 1'b0;
          #1;
        end
      endcase
      chk("LOCK_FLAG", k == 0, LOCK_FLAG);
    end
    wr(sbdlwb_pkg::REG_TAG_ENABLE, 32'(sbdlwb_pkg::TAG_EN_LARGEST));
    rd(sbdlwb_pkg::REG_TAG_ENABLE, 32'h7f80);
    STORED_TAG_BITS <= A[31:17] ^ 15'h007f;
    STORED_TAG_PARITY <= ^(A[31:17] & 15'h7f80);
    cmd(sbdlwb_pkg::CMD_LOAD_LOCKED, A, 1'b0);
    chk("TAG_HIT", 1, TAG_HIT);
    chk("TAG_PARITY_ERROR", 0, TAG_PARITY_ERROR);
    wr(sbdlwb_pkg::REG_TAG_ENABLE, 32'(sbdlwb_pkg::TAG_EN_SMALLEST));
    cmd(sbdlwb_pkg::CMD_LOAD_LOCKED, A, 1'b0);
    chk("TAG_HIT", 0, TAG_HIT);
    cmd(sbdlwb_pkg::CMD_DMA_WRITE, A, 1'b0);
    chk("DCACHE_INVALIDATE_REQUEST", 0, DCACHE_INVALIDATE_REQUEST);
    STORED_TAG_BITS <= A[31:17];
    STORED_TAG_PARITY <= ^A[31:17];
    cmd(sbdlwb_pkg::CMD_DMA_MASKED_WRITE, A, 1'b0);
    chk("DCACHE_INVALIDATE_REQUEST", 1, DCACHE_INVALIDATE_REQUEST);
    chk("CPU_INVALIDATE_INDEX", A[12:5], CPU_INVALIDATE_INDEX);
    STORED_TAG_VALID <= 1'b0;
    wr(sbdlwb_pkg::REG_CONTROL, 32'h0);
    cmd(sbdlwb_pkg::CMD_DMA_WRITE, A + 34'h20, 1'b0);
    chk("DCACHE_INVALIDATE_REQUEST", 1, DCACHE_INVALIDATE_REQUEST);
    wr(sbdlwb_pkg::REG_CONTROL, 32'h1);
    for (int i = 0; i < 4; i++) begin
      fill(fk[i], 29'h1a5 + 29'(i));
      chk("DCACHE_INVALIDATE_REQUEST", i < 2, DCACHE_INVALIDATE_REQUEST);
      if (i < 2) chk("CPU_INVALIDATE_INDEX", 8'ha5 + 8'(i), CPU_INVALIDATE_INDEX);
    end
    // Memory held off: the buffer fills, then the latch takes one more
    for (int i = 0; i < 5; i++) exp_q.push_back(ent(i));
    push(0);
    rdreq(29'h1ff);
    wait_for(MEM_RD_START, 1'b1, 8, n);
    chk("read wait", 1, n);
    for (int i = 1; i < 6; i++) begin
      push(i);
      if (i == 3) chk("WB_FULL", 1, WB_FULL);
      if (i == 3) rd(sbdlwb_pkg::REG_STATUS, 32'h402);
    end
    chk("WB_STALL", 1, WB_STALL);
    rdreq(ent(1).line_addr);
    repeat (5) @(posedge CLK);
    #1 chk("RD_PENDING", 1, RD_PENDING);
    go <= 1'b1;
    wait_for(MEM_RD_START, 1'b1, 100, n);
    chk("retired", 2, ret_cnt);
    chk("MEM_RD_LINE", 29'h101, MEM_RD_LINE);
    chk("WB_STALL", 0, WB_STALL);
    go <= 1'b0;
    cmd(sbdlwb_pkg::CMD_DMA_FLUSH, 34'h0, 1'b0);
    chk("FLUSH_BUSY", 1, FLUSH_BUSY);
    go <= 1'b1;
    wait_for(FLUSH_BUSY, 1'b0, 200, n);
    chk("retired", 5, ret_cnt);
    rd(sbdlwb_pkg::REG_STATUS, 32'h0);
    end_sim();
  end
endmodule
